// ---- shared/serial_break_pkg.sv ----
// Constants, field layouts and state codes for the serial channel with timer
package serial_break_pkg;
  localparam int ADDR_W = 8;
  // Register byte addresses
  localparam logic [ADDR_W-1:0] OFS_FORMAT = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_BITRATE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_TX_HOLD = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_RX_HOLD = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_ORDER = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_T_START = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_T_CTL = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_T_COUNT = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_T_CONST = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_STBY_ONE = 8'h2c;
  localparam logic [ADDR_W-1:0] OFS_STBY_TWO = 8'h30;
  // Status flag and other register bit positions
  localparam int F_TX_EMPTY = 7;
  localparam int F_RX_FULL = 6;
  localparam int F_OVERRUN = 5;
  localparam int F_FRAMING = 4;
  localparam int F_PARITY = 3;
  localparam int F_TEND = 2;
  localparam int F_MPB = 1;
  localparam int F_MPBT = 0;
  localparam int ORDER_DIR = 3;
  localparam int T_RUN = 0;
  localparam int T_MATCH = 7;
  localparam int T_IRQ_EN = 6;
  localparam int SERIAL_STBY = 0;
  localparam int TIMER_STBY = 12;
  // Reset values
  localparam logic [7:0] FLAGS_RST = 8'h84;
  localparam logic [7:0] BITRATE_RST = 8'hff;
  localparam logic [7:0] ORDER_RST = 8'h00;
  localparam logic [15:0] T_CONST_RST = 16'hffff;
  // Oversampling: 16 ticks per bit, sample in the middle
  localparam logic [3:0] SUB_MID = 4'h7;
  localparam logic [3:0] SUB_LAST = 4'hf;
  typedef struct packed {
    logic tx_empty_irq_en;
    logic rx_irq_en;
    logic transmitter_on;
    logic receiver_on;
    logic multiproc_irq_en;
    logic tx_end_irq_en;
    logic clock_source_sel_hi;
    logic clock_source_sel_lo;
  } serial_control_t;
  typedef struct packed {
    logic sync_mode;
    logic char_length_sel;
    logic parity_on;
    logic parity_odd;
    logic two_stop;
    logic multiproc_mode;
    logic [1:0] clk_div_sel;
  } serial_format_mode_t;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_SHIFT = 3'b010,
    RX_STOP = 3'b100
  } rx_state_t;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SHIFT = 2'b10
  } tx_state_t;
endpackage

// ---- rtl/serial_break_top.sv ----
// Asynchronous serial channel with interval timer for break checking
// Summary of operation
// - Receiver shifts pin data in, moves finished byte to holding
// - Receive shifter has no address on the register bus
// - Receive holding: 8-bit, read-only, last accepted character; an overrun keeps the older one
// - Shifter and holding register double-buffer received characters
// - Transmit holding moves to idle shifter and is serialized out
// - Transmit shifter hidden; holding always readable and writable
// - Status flags 7:2 set by hardware only; writing 0 clears, 1 keeps; clearing 7 clears 2 too
// - Bit order selects LSB or MSB first; 7-bit needs LSB first
// - Channel has own baud generator programmed by 8-bit divisor
// - Timer 16-bit up-counter runs on a selectable divided clock
// - Timer run bit starts counting at 1, stops at 0
// - Interval match sets match flag, requests interrupt if enabled
// - Framing error sets its flag; software then starts the timer
// - Clearing receiver enable stops all reception at once
// - Control bits 7, 6, 2 gate tx-empty, rx, tx-end requests
// - Control bit 5 enables transmitter, bit 4 enables receiver
// - Control bits 1:0 pick clock source; 00 internal, pin unused
// - Format bit 7 async, bit 6 length, bit 5 parity, bit 3 stops
// - Format bit 4 parity sense; bit 2 multiprocessor gates its enable
// - Match flag set when counter equals the interval constant
`timescale 1ns/100ps
module serial_break_top
  import serial_break_pkg::*;
(
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  // APB slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [serial_break_pkg::ADDR_W-1:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // Serial line
  input wire logic SERIAL_IN_PIN_IN,
  output logic SERIAL_OUT_PIN_OUT,
  input wire logic SERIAL_CLK_IN,
  output logic SERIAL_CLK_OUT,
  output logic SERIAL_CLK_OE_N_OUT,
  // Interrupt requests
  output logic TX_EMPTY_IRQ_OUT,
  output logic RX_FULL_IRQ_OUT,
  output logic RX_ERROR_IRQ_OUT,
  output logic TX_END_IRQ_OUT,
  output logic MATCH_IRQ_OUT
);
  import serial_break_pkg::*;

  // Mask for a free-running prescaler: /1, /4, /16, /64
  function automatic logic [5:0] serial_mask(input logic [1:0] sel);
    serial_mask = 6'h00;
    case (sel)
      2'h1: serial_mask = 6'h03;
      2'h2: serial_mask = 6'h0f;
      2'h3: serial_mask = 6'h3f;
      default: serial_mask = 6'h00;
    endcase
  endfunction

  // Timer prescaler: /8, /32, /128, /512
  function automatic logic [8:0] timer_mask(input logic [1:0] sel);
    timer_mask = 9'h007;
    case (sel)
      2'h1: timer_mask = 9'h01f;
      2'h2: timer_mask = 9'h07f;
      2'h3: timer_mask = 9'h1ff;
      default: timer_mask = 9'h007;
    endcase
  endfunction

  function automatic logic [7:0] flip8(input logic [7:0] d);
    for (int i = 0; i < 8; i++)
    begin
      flip8[i] = d[7-i];
    end
  endfunction

  // Bits after the start bit: data, parity and multiprocessor bit
  function automatic logic [3:0] payload_len(input serial_format_mode_t m);
    payload_len = 4'(m.char_length_sel ? 7 : 8) + 4'(m.parity_on)
      + 4'(m.multiproc_mode);
  endfunction

  serial_format_mode_t format_q;
  serial_control_t control_q;
  logic [7:0] bitrate_q, tx_hold_q, rx_hold_q, flags_q, order_q;
  logic [7:0] t_ctl_q;
  logic t_run_q;
  logic [15:0] t_count_q, t_const_q, stby_one_q, stby_two_q;
  logic [31:0] prdata_q;
  logic rx_meta_q, rx_line_q, ck_meta_q, ck_line_q;
  logic [7:0] flag_keep;
  logic [5:0] pre_q;
  logic [7:0] baud_q;
  logic [8:0] t_pre_q;
  rx_state_t rx_state_q;
  tx_state_t tx_state_q;
  logic [3:0] rx_sub_q, rx_idx_q, tx_sub_q, tx_left_q;
  logic [9:0] rx_shift_q;
  logic [11:0] tx_shift_q;
  logic tx_line_q, sck_q;

  logic wr_en, setup, addr_ok, tick16, msb_first, serial_run;
  logic rx_stop_evt, rx_accept, rx_par_bad, rx_mpb, tx_load, tx_end_evt;
  logic t_tick, t_hit;
  logic [3:0] plen;
  logic [9:0] rx_frame;
  logic [7:0] rx_data;
  logic [11:0] tx_word;

  assign wr_en = PSEL_IN && PENABLE_IN && PWRITE_IN;
  assign setup = PSEL_IN && !PENABLE_IN;
  assign plen = payload_len(format_q);
  assign msb_first = order_q[ORDER_DIR]
    && !format_q.char_length_sel;
  assign serial_run = !stby_one_q[SERIAL_STBY];

  // Only the documented registers decode; the shifters have no address
  always_comb
  begin
    case (PADDR_IN)
      OFS_FORMAT, OFS_BITRATE, OFS_CONTROL, OFS_TX_HOLD, OFS_FLAGS,
      OFS_RX_HOLD, OFS_ORDER, OFS_T_START, OFS_T_CTL, OFS_T_COUNT,
      OFS_T_CONST, OFS_STBY_ONE, OFS_STBY_TWO: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // Read data captured in setup so the access phase needs no wait
  always_ff @(posedge CLK_IN)
  begin
    if (!RST_N_IN)
      prdata_q <= 32'h0000_0000;
    else if (setup)
    begin
      case (PADDR_IN)
        OFS_FORMAT: prdata_q <= {24'h000000, format_q};
        OFS_BITRATE: prdata_q <= {24'h000000, bitrate_q};
        OFS_CONTROL: prdata_q <= {24'h000000, control_q};
        OFS_TX_HOLD: prdata_q <= {24'h000000, tx_hold_q};
        OFS_FLAGS: prdata_q <= {24'h000000, flags_q};
        OFS_RX_HOLD: prdata_q <= {24'h000000, rx_hold_q};
        OFS_ORDER: prdata_q <= {24'h000000, order_q};
        OFS_T_START: prdata_q <= {31'h0000_0000, t_run_q};
        OFS_T_CTL: prdata_q <= {24'h000000, t_ctl_q};
        OFS_T_COUNT: prdata_q <= {16'h0000, t_count_q};
        OFS_T_CONST: prdata_q <= {16'h0000, t_const_q};
        OFS_STBY_ONE: prdata_q <= {16'h0000, stby_one_q};
        OFS_STBY_TWO: prdata_q <= {16'h0000, stby_two_q};
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign PRDATA_OUT = prdata_q;
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !addr_ok;

  // Plain software registers
  always_ff @(posedge CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      format_q <= '0;
      bitrate_q <= BITRATE_RST;
      tx_hold_q <= 8'h00;
      order_q <= ORDER_RST;
      stby_one_q <= 16'h0000;
      stby_two_q <= 16'h0000;
      t_const_q <= T_CONST_RST;
      t_run_q <= 1'b0;
    end
    else if (wr_en)
    begin
      case (PADDR_IN)
        OFS_FORMAT:
          format_q <= serial_format_mode_t'(PWDATA_IN[7:0]);
        OFS_BITRATE: bitrate_q <= PWDATA_IN[7:0];
        OFS_TX_HOLD: tx_hold_q <= PWDATA_IN[7:0];
        OFS_ORDER: order_q <= PWDATA_IN[7:0];
        OFS_STBY_ONE: stby_one_q <= PWDATA_IN[15:0];
        OFS_STBY_TWO: stby_two_q <= PWDATA_IN[15:0];
        OFS_T_CONST: t_const_q <= PWDATA_IN[15:0];
        OFS_T_START: t_run_q <= PWDATA_IN[T_RUN];
        default: ;
      endcase
    end
  end

  // Control; hardware drops the multiprocessor enable on an ID frame
  always_ff @(posedge CLK_IN)
  begin
    if (!RST_N_IN)
      control_q <= '0;
    else if (wr_en && PADDR_IN == OFS_CONTROL)
      control_q <= serial_control_t'(PWDATA_IN[7:0]);
    else if (rx_stop_evt && rx_mpb && format_q.multiproc_mode)
      control_q.multiproc_irq_en <= 1'b0;
  end

  // Input synchronisers
  always_ff @(posedge CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      rx_meta_q <= 1'b1;
      rx_line_q <= 1'b1;
      ck_meta_q <= 1'b0;
      ck_line_q <= 1'b0;
    end
    else
    begin
      rx_meta_q <= SERIAL_IN_PIN_IN;
      rx_line_q <= rx_meta_q;
      ck_meta_q <= SERIAL_CLK_IN;
      ck_line_q <= ck_meta_q;
    end
  end

  // Baud generator: prescaler then divisor reload, 16 ticks per bit
  assign tick16 = serial_run && ((pre_q & serial_mask(format_q.clk_div_sel))
    == serial_mask(format_q.clk_div_sel)) && baud_q == 8'h00;

  always_ff @(posedge CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      pre_q <= 6'h00;
      baud_q <= 8'h00;
    end
    else if (serial_run)
    begin
      pre_q <= pre_q + 6'h01;
      if ((pre_q & serial_mask(format_q.clk_div_sel))
        == serial_mask(format_q.clk_div_sel))
        baud_q <= (baud_q == 8'h00) ? bitrate_q : baud_q - 8'h01;
    end
  end

  // Receiver
  always_ff @(posedge CLK_IN)
  begin
    if (!RST_N_IN || !control_q.receiver_on)
    begin
      rx_state_q <= RX_IDLE;
      rx_sub_q <= 4'h0;
      rx_idx_q <= 4'h0;
      rx_shift_q <= 10'h000;
    end
    else if (tick16)
    begin
      case (rx_state_q)
        RX_IDLE:
        begin
          rx_sub_q <= 4'h0;
          rx_idx_q <= 4'h0;
          if (!rx_line_q)
            rx_state_q <= RX_SHIFT;
        end
        RX_SHIFT:
        begin
          rx_sub_q <= rx_sub_q + 4'h1;
          if (rx_sub_q == SUB_MID)
          begin
            rx_idx_q <= rx_idx_q + 4'h1;
            if (rx_idx_q == 4'h0 && rx_line_q)
              rx_state_q <= RX_IDLE;
            else if (rx_idx_q != 4'h0)
              rx_shift_q <= {rx_line_q, rx_shift_q[9:1]};
            if (rx_idx_q == plen)
              rx_state_q <= RX_STOP;
          end
        end
        RX_STOP:
        begin
          rx_sub_q <= rx_sub_q + 4'h1;
          if (rx_sub_q == SUB_MID)
            rx_state_q <= RX_IDLE;
        end
        default: rx_state_q <= RX_IDLE;
      endcase
    end
  end

  // Frame fields; shifter fills from the top, so realign by frame length
  // Gated by the enable so a frame ending as it drops is not taken
  assign rx_stop_evt = tick16 && control_q.receiver_on
    && rx_state_q == RX_STOP && rx_sub_q == SUB_MID;
  assign rx_frame = rx_shift_q >> (4'd10 - plen);
  assign rx_data = msb_first ? flip8(rx_frame[7:0])
    : (format_q.char_length_sel ? {1'b0, rx_frame[6:0]} : rx_frame[7:0]);
  always_comb
  begin
    logic [3:0] n;
    n = format_q.char_length_sel ? 4'd7 : 4'd8;
    rx_par_bad = format_q.parity_on
      && ((^(rx_frame[7:0] & (format_q.char_length_sel ? 8'h7f : 8'hff)))
      ^ format_q.parity_odd) != rx_frame[n];
    rx_mpb = format_q.multiproc_mode
      && rx_frame[n + 4'(format_q.parity_on)];
  end
  // Multiprocessor filter skips data frames while its enable is set
  assign rx_accept = rx_stop_evt && !(format_q.multiproc_mode
    && control_q.multiproc_irq_en && !rx_mpb);

  // Holding register keeps the last character; overrun keeps the old one
  always_ff @(posedge CLK_IN)
  begin
    if (!RST_N_IN)
      rx_hold_q <= 8'h00;
    else if (rx_accept && !flags_q[F_RX_FULL])
      rx_hold_q <= rx_data;
  end

  // Transmit frame: start, data, parity, multiproc bit, stop ones
  always_comb
  begin
    logic [7:0] d;
    int n;
    d = msb_first ? flip8(tx_hold_q) : tx_hold_q;
    n = format_q.char_length_sel ? 7 : 8;
    tx_word = 12'hfff;
    tx_word[0] = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      if (i < n)
        tx_word[i+1] = d[i];
    end
    if (format_q.parity_on)
    begin
      tx_word[n+1] = (^(d & (format_q.char_length_sel ? 8'h7f : 8'hff)))
        ^ format_q.parity_odd;
      n = n + 1;
    end
    if (format_q.multiproc_mode)
      tx_word[n+1] = flags_q[F_MPBT];
  end

  assign tx_load = tx_state_q == TX_IDLE && control_q.transmitter_on
    && !flags_q[F_TX_EMPTY];
  assign tx_end_evt = tick16 && tx_state_q == TX_SHIFT
    && tx_sub_q == SUB_LAST && tx_left_q == 4'h1;

  always_ff @(posedge CLK_IN)
  begin
    if (!RST_N_IN || !control_q.transmitter_on)
    begin
      tx_state_q <= TX_IDLE;
      tx_shift_q <= 12'hfff;
      tx_sub_q <= 4'h0;
      tx_left_q <= 4'h0;
    end
    else if (tx_load)
    begin
      tx_state_q <= TX_SHIFT;
      tx_shift_q <= tx_word;
      tx_sub_q <= 4'h0;
      tx_left_q <= plen + 4'd2 + 4'(format_q.two_stop);
    end
    else if (tick16 && tx_state_q == TX_SHIFT)
    begin
      tx_sub_q <= tx_sub_q + 4'h1;
      if (tx_sub_q == SUB_LAST)
      begin
        tx_shift_q <= {1'b1, tx_shift_q[11:1]};
        tx_left_q <= tx_left_q - 4'h1;
        if (tx_left_q == 4'h1)
          tx_state_q <= TX_IDLE;
      end
    end
  end

  // Line and bit clock outputs; pin unused unless internal clock is exported
  always_ff @(posedge CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      tx_line_q <= 1'b1;
      sck_q <= 1'b1;
    end
    else
    begin
      tx_line_q <= (tx_state_q == TX_SHIFT) ? tx_shift_q[0] : 1'b1;
      sck_q <= control_q.clock_source_sel_hi ? ck_line_q
        : (tx_sub_q < 4'h8);
    end
  end

  assign SERIAL_OUT_PIN_OUT = tx_line_q;
  assign SERIAL_CLK_OUT = sck_q;
  assign SERIAL_CLK_OE_N_OUT = !(control_q.clock_source_sel_lo
    && !control_q.clock_source_sel_hi);

  // Status flags 7:2: writing 0 clears, writing 1 keeps, clearing 7 also clears 2, hardware set wins
  assign flag_keep = (wr_en && PADDR_IN == OFS_FLAGS) ? PWDATA_IN[7:0]
    : 8'hff;

  always_ff @(posedge CLK_IN)
  begin
    if (!RST_N_IN)
      flags_q <= FLAGS_RST;
    else
    begin
      flags_q[F_TX_EMPTY] <= (flags_q[F_TX_EMPTY] & flag_keep[F_TX_EMPTY])
        | tx_load;
      flags_q[F_RX_FULL] <= (flags_q[F_RX_FULL] & flag_keep[F_RX_FULL])
        | rx_accept;
      flags_q[F_OVERRUN] <= (flags_q[F_OVERRUN] & flag_keep[F_OVERRUN])
        | (rx_accept && flags_q[F_RX_FULL]);
      flags_q[F_FRAMING] <= (flags_q[F_FRAMING] & flag_keep[F_FRAMING])
        | (rx_accept && !rx_line_q);
      flags_q[F_PARITY] <= (flags_q[F_PARITY] & flag_keep[F_PARITY])
        | (rx_accept && rx_par_bad);
      flags_q[F_TEND] <= (flags_q[F_TEND] & flag_keep[F_TEND]
        & flag_keep[F_TX_EMPTY]) | (tx_end_evt && flags_q[F_TX_EMPTY]);
      flags_q[F_MPB] <= rx_stop_evt ? rx_mpb : flags_q[F_MPB];
      flags_q[F_MPBT] <= (wr_en && PADDR_IN == OFS_FLAGS)
        ? PWDATA_IN[F_MPBT] : flags_q[F_MPBT];
    end
  end

  assign TX_EMPTY_IRQ_OUT = control_q.tx_empty_irq_en
    && flags_q[F_TX_EMPTY];
  assign RX_FULL_IRQ_OUT = control_q.rx_irq_en
    && flags_q[F_RX_FULL];
  assign RX_ERROR_IRQ_OUT = control_q.rx_irq_en && (flags_q[F_OVERRUN]
    || flags_q[F_FRAMING] || flags_q[F_PARITY]);
  assign TX_END_IRQ_OUT = control_q.tx_end_irq_en && flags_q[F_TEND];

  // Interval timer
  assign t_tick = t_run_q && !stby_two_q[TIMER_STBY]
    && (t_pre_q & timer_mask(t_ctl_q[1:0])) == timer_mask(t_ctl_q[1:0]);
  assign t_hit = t_tick && t_count_q == t_const_q;

  always_ff @(posedge CLK_IN)
  begin
    if (!RST_N_IN || !t_run_q)
      t_pre_q <= 9'h000;
    else if (!stby_two_q[TIMER_STBY])
      t_pre_q <= t_pre_q + 9'h001;
  end

  always_ff @(posedge CLK_IN)
  begin
    if (!RST_N_IN)
      t_count_q <= 16'h0000;
    else if (wr_en && PADDR_IN == OFS_T_COUNT)
      t_count_q <= PWDATA_IN[15:0];
    else if (t_hit)
      t_count_q <= 16'h0000;
    else if (t_tick)
      t_count_q <= t_count_q + 16'h0001;
  end

  always_ff @(posedge CLK_IN)
  begin
    if (!RST_N_IN)
      t_ctl_q <= 8'h00;
    else
    begin
      if (wr_en && PADDR_IN == OFS_T_CTL)
      begin
        t_ctl_q[T_IRQ_EN] <= PWDATA_IN[T_IRQ_EN];
        t_ctl_q[1:0] <= PWDATA_IN[1:0];
      end
      t_ctl_q[T_MATCH] <= (t_ctl_q[T_MATCH] && !(wr_en
        && PADDR_IN == OFS_T_CTL && !PWDATA_IN[T_MATCH])) || t_hit;
    end
  end

  assign MATCH_IRQ_OUT = t_ctl_q[T_IRQ_EN] && t_ctl_q[T_MATCH];

  // Checks
  a_match_sets_flag: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    t_hit && !(wr_en && PADDR_IN == OFS_T_COUNT)
    |=> t_ctl_q[T_MATCH] && t_count_q == 16'h0000)
    else $error("match did not set flag and restart counter");
  a_timer_stopped: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    !t_run_q && !(wr_en && PADDR_IN == OFS_T_COUNT) |=> $stable(t_count_q))
    else $error("counter moved while stopped");
  a_rx_off_idle: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    !control_q.receiver_on
    |=> rx_state_q == RX_IDLE && !$rose(flags_q[F_RX_FULL]))
    else $error("reception went on with receiver off");
  a_fer_low_stop: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    rx_accept && !rx_line_q |=> flags_q[F_FRAMING])
    else $error("low stop bit gave no framing error");
  a_flag_one_keeps: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    wr_en && PADDR_IN == OFS_FLAGS && PWDATA_IN[F_RX_FULL]
    && flags_q[F_RX_FULL] |=> flags_q[F_RX_FULL])
    else $error("writing 1 cleared a flag");
  a_tx_load_empty: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    tx_load |=> tx_state_q == TX_SHIFT && flags_q[F_TX_EMPTY]
    ##1 SERIAL_OUT_PIN_OUT == 1'b0)
    else $error("load did not start a frame");
  a_tx_off_line: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    !control_q.transmitter_on [*2] |=> SERIAL_OUT_PIN_OUT)
    else $error("line driven low with transmitter off");
  a_rx_hold_copy: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    rx_accept && !flags_q[F_RX_FULL] |=> rx_hold_q == $past(rx_data)
    && flags_q[F_RX_FULL])
    else $error("frame not copied to holding register");
  a_rx_err_irq: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    rx_accept && !rx_line_q && control_q.rx_irq_en
    && !(wr_en && PADDR_IN == OFS_CONTROL) |=> RX_ERROR_IRQ_OUT)
    else $error("framing error gave no error request");
endmodule

// ---- sim/serial_peer.sv ----
// Far-end serial partner: sends frames and collects received ones
`timescale 1ns/100ps
module serial_peer #(
  parameter int BIT_CLKS = 16
) (
  input wire logic clk_in,
  input wire logic line_in,
  output logic line_out,
  output logic [7:0] got_out,
  output int got_count_out
);
  initial line_out = 1'b1;
  initial got_count_out = 0;
  // Stop level 0 leaves the line low afterwards, which is a break
  task automatic send(input logic [7:0] b, input logic stop);
    line_out <= 1'b0;
    repeat (BIT_CLKS) @(posedge clk_in);
    for (int i = 0; i < 8; i++)
    begin
      line_out <= b[i];
      repeat (BIT_CLKS) @(posedge clk_in);
    end
    line_out <= stop;
    repeat (BIT_CLKS) @(posedge clk_in);
  endtask
  task automatic idle();
    line_out <= 1'b1;
    repeat (BIT_CLKS) @(posedge clk_in);
  endtask
  // Mid-bit sampling, LSB first
  always
  begin
    @(negedge line_in);
    repeat (BIT_CLKS / 2) @(posedge clk_in);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT_CLKS) @(posedge clk_in);
      got_out[i] = line_in;
    end
    repeat (BIT_CLKS) @(posedge clk_in);
    got_count_out++;
  end
endmodule

// ---- sim/serial_break_top_tb.sv ----
// Self-checking bench for the serial channel with interval timer
`timescale 1ns/100ps
module serial_break_top_tb;
  import serial_break_pkg::*;
  logic clk, rst_n, psel, penable, pwrite, sck_in, err;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd, cnt;
  logic pready, pslverr, line_rx, line_tx, sck_out, sck_oe_n;
  logic irq_txe, irq_rxf, irq_rxe, irq_tend, irq_match;
  logic [7:0] got;
  int got_n, bad_count, total_checks, lows, n;
  serial_break_top serial_break_top_i (
    .CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .SERIAL_IN_PIN_IN(line_rx),
    .SERIAL_OUT_PIN_OUT(line_tx), .SERIAL_CLK_IN(sck_in),
    .SERIAL_CLK_OUT(sck_out), .SERIAL_CLK_OE_N_OUT(sck_oe_n),
    .TX_EMPTY_IRQ_OUT(irq_txe), .RX_FULL_IRQ_OUT(irq_rxf),
    .RX_ERROR_IRQ_OUT(irq_rxe), .TX_END_IRQ_OUT(irq_tend),
    .MATCH_IRQ_OUT(irq_match));
  serial_peer serial_peer_i (.clk_in(clk), .line_in(line_tx),
    .line_out(line_rx), .got_out(got), .got_count_out(got_n));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Expired wait counts as a mismatch and ends the run
  task automatic guard(input logic ok);
    check(32'(ok), 32'h1);
    if (ok !== 1'b1)
      complete_run();
  endtask
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    guard(n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
  endtask
  task automatic wait_flag(input int b);
    int k;
    for (k = 0; k < 400; k++)
    begin
      apb(1'b0, OFS_FLAGS, 32'h0);
      if (rd[b] === 1'b1)
        break;
    end
    guard(k < 400);
  endtask
  // Transmit one byte and wait for the partner to collect it
  task automatic tx(input logic [7:0] b, input logic [7:0] e);
    int k;
    k = got_n;
    wait_flag(F_TX_EMPTY);
    apb(1'b1, OFS_TX_HOLD, {24'h0, b});
    rchk(OFS_TX_HOLD, {24'h0, b});
    apb(1'b1, OFS_FLAGS, 32'h04);
    for (n = 0; n < 900 && got_n == k; n++)
      @(posedge clk);
    guard(got_n == k + 1);
    check(got, e);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    repeat (100000) @(posedge clk);
    guard(1'b0);
  end
  initial
  begin
    {rst_n, psel, penable, pwrite, sck_in} = 5'b0;
    paddr = '0;
    pwdata = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check(line_tx, 1'b1);
    check(sck_out, 1'b1);
    check(sck_oe_n, 1'b1);
    rchk(OFS_FLAGS, {24'h0, FLAGS_RST});
    rchk(OFS_BITRATE, {24'h0, BITRATE_RST});
    rchk(OFS_T_CONST, {16'h0, T_CONST_RST});
    rchk(8'hfc, 32'h0);
    check(err, 1'b1);
    apb(1'b1, OFS_BITRATE, 32'h0);
    // Divisor counter still runs down the reset divisor first
    repeat (256) @(posedge clk);
    rchk(OFS_BITRATE, 32'h0);
    apb(1'b1, OFS_FORMAT, 32'h0);
    rchk(OFS_FORMAT, 32'h0);
    apb(1'b1, OFS_CONTROL, 32'h70);
    serial_peer_i.send(8'ha5, 1'b1);
    wait_flag(F_RX_FULL);
    check(irq_rxf, 1'b1);
    apb(1'b1, OFS_RX_HOLD, 32'h11);
    rchk(OFS_RX_HOLD, 32'ha5);
    serial_peer_i.send(8'h5a, 1'b1);
    wait_flag(F_OVERRUN);
    rchk(OFS_RX_HOLD, 32'ha5);
    apb(1'b1, OFS_FLAGS, 32'hff);
    rchk(OFS_FLAGS, 32'he5);
    apb(1'b1, OFS_FLAGS, 32'h84);
    rchk(OFS_FLAGS, 32'h84);
    check(irq_rxf, 1'b0);
    tx(8'h3c, 8'h3c);
    tx(8'h81, 8'h81);
    apb(1'b1, OFS_ORDER, 32'h08);
    tx(8'h12, 8'h48);
    apb(1'b1, OFS_FORMAT, 32'h40);
    tx(8'h3c, 8'hbc);
    apb(1'b1, OFS_FORMAT, 32'h0);
    apb(1'b1, OFS_CONTROL, 32'hf5);
    wait_flag(F_TEND);
    check(irq_tend, 1'b1);
    check(irq_txe, 1'b1);
    check(sck_oe_n, 1'b0);
    apb(1'b1, OFS_CONTROL, 32'h70);
    check(irq_tend, 1'b0);
    check(irq_txe, 1'b0);
    check(sck_oe_n, 1'b1);
    serial_peer_i.send(8'h00, 1'b0);
    wait_flag(F_FRAMING);
    check(irq_rxe, 1'b1);
    apb(1'b1, OFS_T_CONST, 32'h3);
    apb(1'b1, OFS_T_CTL, 32'h40);
    apb(1'b1, OFS_T_START, 32'h1);
    lows = 0;
    repeat (3)
    begin
      for (n = 0; n < 40 && irq_match !== 1'b1; n++)
        @(posedge clk);
      guard(irq_match === 1'b1);
      lows += (line_rx === 1'b0);
      apb(1'b1, OFS_T_CTL, 32'h40);
      check(irq_match, 1'b0);
    end
    check(32'(lows), 32'h3);
    apb(1'b1, OFS_T_START, 32'h0);
    apb(1'b0, OFS_T_COUNT, 32'h0);
    cnt = rd;
    repeat (40) @(posedge clk);
    rchk(OFS_T_COUNT, cnt);
    apb(1'b1, OFS_CONTROL, 32'h20);
    apb(1'b1, OFS_FLAGS, 32'h84);
    serial_peer_i.idle();
    serial_peer_i.send(8'h66, 1'b1);
    repeat (40) @(posedge clk);
    rchk(OFS_FLAGS, 32'h84);
    complete_run();
  end
endmodule
